// file: design/ctb_pkg.sv
// Constants, field layout and state type of the capture timer base group
package ctb_pkg;
  // ==========================================================
  // Sizes
  localparam int CNT_W = 16;
  localparam int NCH = 8;
  localparam int ADDR_W = 8;
  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] OFF_CFG0 = 8'h00;
  localparam logic [7:0] OFF_CFG1 = 8'h04;
  localparam logic [7:0] OFF_COUNT = 8'h08;
  localparam logic [7:0] OFF_OCFG0 = 8'h0c;
  localparam logic [7:0] OFF_FSEL = 8'h10;
  localparam logic [7:0] OFF_FEN = 8'h14;
  localparam logic [7:0] OFF_STAT = 8'h18;
  localparam logic [7:0] OFF_CCFG = 8'h20;
  localparam logic [7:0] OFF_CAPV = 8'h40;
  localparam logic [7:0] OFF_CMP = 8'h60;
  localparam logic [7:0] OFF_TDIV6 = 8'h80;
  localparam logic [7:0] OFF_TDIV7 = 8'h84;
  // ==========================================================
  // Field positions
  localparam int CFG0_SRC = 0;
  localparam int CFG0_RATIO = 2;
  localparam int CFG0_IRQ = 7;
  localparam int CFG1_RUN = 0;
  localparam int CFG1_EXT = 1;
  localparam int CFG1_MATCH = 2;
  localparam int CFG1_OVF = 3;
  localparam int CFG1_DIR = 4;
  localparam int OCFG0_SHAPE = 0;
  localparam int OCFG0_BASE_RESET_SRC_SEL = 3;
  localparam int CCFG_EDGE = 0;
  localparam int CCFG_FILT = 2;
  localparam int CCFG_GATE = 4;
  localparam int CCFG_GOC = 5;
  localparam int CCFG_GSC = 6;
  localparam int CCFG_PR = 7;
  localparam int STAT_BIRQ = 0;
  localparam int STAT_CIRQ = 8;
  // ==========================================================
  // Encodings and values
  localparam logic [1:0] SRC_NB = 2'h1;
  localparam logic [1:0] SRC_QUAD = 2'h2;
  localparam logic [1:0] DIR_UP = 2'h0;
  localparam logic [1:0] DIR_UPDN = 2'h1;
  localparam logic [1:0] DIR_QUAD = 2'h2;
  localparam logic [1:0] FLT_F1 = 2'h1;
  localparam logic [1:0] FLT_BASE = 2'h2;
  localparam logic [1:0] EDG_RISE = 2'h1;
  localparam logic [1:0] EDG_FALL = 2'h2;
  localparam logic [1:0] EDG_BOTH = 2'h3;
  localparam logic [1:0] IRQ_B9 = 2'h0;
  localparam logic [1:0] IRQ_B14 = 2'h1;
  localparam logic [4:0] RATIO_NODIV = 5'h1f;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [15:0] CNT_TOP = 16'hffff;
  localparam logic [2:0] FILT_ONES = 3'h7;
  localparam logic [2:0] FILT_ZEROS = 3'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================================
  // Whole state of one group
  typedef struct packed {
    logic [1:0] src;
    logic [4:0] ratio;
    logic [1:0] irqsel;
    logic run, ext_en, match_en, ovf_en;
    logic [1:0] dirsel;
    logic [2:0] shape;
    logic base_reset_src_sel;
    logic [NCH-1:0] fsel, fen;
    logic [NCH-1:0][7:0] ccfg;
    logic [NCH-1:0][CNT_W-1:0] cmp, cap;
    logic [1:0][CNT_W-1:0] tdiv, pcnt;
    logic [1:0] blocked;
    logic [CNT_W-1:0] count;
    logic down, pend, prst, birq;
    logic [5:0] divcnt;
    logic [1:0] qa_s, qb_s, ext_s;
    logic qa_d, qb_d;
    logic [NCH-1:0][1:0] pin_s;
    logic [NCH-1:0][2:0] fsh;
    logic [NCH-1:0] lvl, cirq;
    logic aw_have, w_have, bvalid, rvalid;
    logic [ADDR_W-1:0] awaddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
  } ctb_state_t;
endpackage

// file: design/ctb_group.sv
// One capture timer group: base timer, eight capture channels, AXI4-Lite registers
//
// The AXI4-Lite interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module ctb_group (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [ctb_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [ctb_pkg::ADDR_W-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input wire logic [ctb_pkg::NCH-1:0] chan_pin,
  input wire logic quad_a,
  input wire logic quad_b,
  input wire logic ext_reset_input,
  input wire logic neighbour_timer_event,
  input wire logic peer_reset_in,
  output logic peer_reset_out,
  output logic base_irq_flag,
  output logic [ctb_pkg::NCH-1:0] capture_irq_flag
);
  import ctb_pkg::*;

  ctb_state_t s_reg, s_next;
  logic tick, hold, ev, qmode, qstep, qup, dn, mtch, ovr;
  logic wr_go, own_rst, birq_ev;
  logic [NCH-1:0] pin, cap_ev;
  logic [31:0] m, wmask;
  logic [15:0] nx;

  // ==========================================================
  // Helpers
  // Byte-lane merge of write data over an old word
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                        input logic [3:0] st);
    merge = o;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        merge[8*b +: 8] = d[8*b +: 8];
      end
    end
  endfunction

  // Carry out of bit b of the counter on an up count
  function automatic logic ovf(input logic [15:0] c, input int b);
    logic [15:0] mk;
    mk = 16'((32'd1 << (b + 1)) - 32'd1);
    ovf = &(c | ~mk);
  endfunction

  // Offset decode: which addresses answer OKAY
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'h0) &&
             (a <= OFF_STAT || (a >= OFF_CCFG && a < OFF_CMP + 8'h20) ||
              a == OFF_TDIV6 || a == OFF_TDIV7);
  endfunction

  // Read-back word of a register
  function automatic logic [31:0] rd_word(input ctb_state_t x, input logic [7:0] a);
    rd_word = 32'h0000_0000;
    case (a)
      OFF_CFG0: begin
        rd_word[CFG0_SRC +: 2] = x.src;
        rd_word[CFG0_RATIO +: 5] = x.ratio;
        rd_word[CFG0_IRQ +: 2] = x.irqsel;
      end
      OFF_CFG1: begin
        rd_word[CFG1_RUN] = x.run;
        rd_word[CFG1_EXT] = x.ext_en;
        rd_word[CFG1_MATCH] = x.match_en;
        rd_word[CFG1_OVF] = x.ovf_en;
        rd_word[CFG1_DIR +: 2] = x.dirsel;
      end
      OFF_COUNT: rd_word[15:0] = x.count; // Live counter
      OFF_OCFG0: begin
        rd_word[OCFG0_SHAPE +: 3] = x.shape;
        rd_word[OCFG0_BASE_RESET_SRC_SEL] = x.base_reset_src_sel;
      end
      OFF_FSEL: rd_word[7:0] = x.fsel;
      OFF_FEN: rd_word[7:0] = x.fen;
      OFF_STAT: begin
        rd_word[STAT_BIRQ] = x.birq;
        rd_word[STAT_CIRQ +: 8] = x.cirq;
      end
      OFF_TDIV6: rd_word[15:0] = x.tdiv[0];
      OFF_TDIV7: rd_word[15:0] = x.tdiv[1];
      default: begin
        case (a[7:5])
          3'h1: begin
            rd_word[7:0] = x.ccfg[a[4:2]];
            rd_word[CCFG_GSC] = 1'b0;
          end
          3'h2: rd_word[15:0] = x.cap[a[4:2]];
          3'h3: rd_word[15:0] = x.cmp[a[4:2]];
          default: rd_word = 32'h0000_0000;
        endcase
      end
    endcase
  endfunction

  // ==========================================================
  // Next-state logic
  always_comb begin
    s_next = s_reg;
    birq_ev = 1'b0;
    own_rst = 1'b0;
    nx = s_reg.count;
    // Two-flop synchronisers for pins
    s_next.qa_s = {s_reg.qa_s[0], quad_a};
    s_next.qb_s = {s_reg.qb_s[0], quad_b};
    s_next.ext_s = {s_reg.ext_s[0], ext_reset_input};
    for (int j = 0; j < NCH; j++) begin
      s_next.pin_s[j] = {s_reg.pin_s[j][0], chan_pin[j]};
      pin[j] = s_reg.pin_s[j][1];
    end
    // Quadrature decode, one step per edge of A or B
    s_next.qa_d = s_reg.qa_s[1];
    s_next.qb_d = s_reg.qb_s[1];
    qstep = (s_reg.qa_s[1] ^ s_reg.qa_d) ^ (s_reg.qb_s[1] ^ s_reg.qb_d);
    qup = s_reg.qa_d ^ s_reg.qb_s[1];
    qmode = s_reg.dirsel == DIR_QUAD;
    // Count source select and 2(n+1) divider
    if (qmode || s_reg.src == SRC_QUAD) begin
      ev = qstep;
    end else if (s_reg.src == SRC_NB) begin
      ev = neighbour_timer_event;
    end else begin
      ev = 1'b1;
    end
    tick = 1'b0;
    if (ev) begin
      if (s_reg.ratio == RATIO_NODIV || s_reg.divcnt == {s_reg.ratio, 1'b1}) begin
        tick = 1'b1;
        s_next.divcnt = 6'h00;
      end else begin
        s_next.divcnt = s_reg.divcnt + 6'h01;
      end
    end
    // Direction of the next step
    if (qmode) begin
      dn = ~qup;
    end else if (s_reg.dirsel == DIR_UPDN) begin
      dn = s_reg.pend || (s_reg.down ? s_reg.count != CNT_RESET : s_reg.count == CNT_TOP);
    end else begin
      dn = 1'b0;
    end
    mtch = s_reg.match_en && !s_reg.fsel[0] && s_reg.fen[0] && s_reg.count == s_reg.cmp[0];
    ovr = s_reg.ovf_en && !dn && ovf(s_reg.count, s_reg.base_reset_src_sel ? 9 : 15);
    hold = !s_reg.run || (s_reg.ext_en && !s_reg.ext_s[1]) || peer_reset_in;
    // Base timer counter
    if (hold) begin
      s_next.count = CNT_RESET;
      s_next.pend = 1'b0;
      s_next.down = 1'b0;
      s_next.divcnt = 6'h00;
      own_rst = !s_reg.run || (s_reg.ext_en && !s_reg.ext_s[1]);
    end else if (tick) begin
      s_next.pend = mtch;
      s_next.down = dn;
      nx = dn ? s_reg.count - 16'h0001 : s_reg.count + 16'h0001;
      if (s_reg.pend && (s_reg.dirsel == DIR_UP || (qmode && !dn))) begin
        s_next.count = CNT_RESET;
        own_rst = 1'b1;
      end else if (ovr) begin
        s_next.count = CNT_RESET;
        own_rst = 1'b1;
      end else begin
        s_next.count = nx;
      end
      case (s_reg.irqsel)
        IRQ_B9: birq_ev = !dn && ovf(s_reg.count, 9);
        IRQ_B14: birq_ev = !dn && ovf(s_reg.count, 14);
        default: birq_ev = !dn && ovf(s_reg.count, 15);
      endcase
    end
    s_next.prst = own_rst;
    // Filters, edge detect and channel enables
    for (int j = 0; j < NCH; j++) begin
      if (s_reg.ccfg[j][CCFG_FILT +: 2] == FLT_F1 ||
          (s_reg.ccfg[j][CCFG_FILT +: 2] == FLT_BASE && tick)) begin
        s_next.fsh[j] = {s_reg.fsh[j][1:0], pin[j]};
      end
      if (s_reg.ccfg[j][CCFG_FILT +: 2] == 2'h0 || s_reg.ccfg[j][CCFG_FILT +: 2] == 2'h3) begin
        s_next.lvl[j] = pin[j];
      end else if (s_next.fsh[j] == FILT_ONES) begin
        s_next.lvl[j] = 1'b1;
      end else if (s_next.fsh[j] == FILT_ZEROS) begin
        s_next.lvl[j] = 1'b0;
      end
      case (s_reg.ccfg[j][CCFG_EDGE +: 2])
        EDG_RISE: cap_ev[j] = s_next.lvl[j] & ~s_reg.lvl[j];
        EDG_FALL: cap_ev[j] = ~s_next.lvl[j] & s_reg.lvl[j];
        EDG_BOTH: cap_ev[j] = s_next.lvl[j] ^ s_reg.lvl[j];
        default: cap_ev[j] = 1'b0;
      endcase
      cap_ev[j] = cap_ev[j] & s_reg.fsel[j] & s_reg.fen[j];
    end
    // Gating and prescaler on channels 6 and 7
    for (int k = 0; k < 2; k++) begin
      if (s_reg.ccfg[6+k][CCFG_GATE] && s_reg.blocked[k]) begin
        cap_ev[6+k] = 1'b0;
      end
      if (cap_ev[6+k] && s_reg.ccfg[6+k][CCFG_PR]) begin
        if (s_reg.pcnt[k] == s_reg.tdiv[k]) begin
          s_next.pcnt[k] = 16'h0000;
        end else begin
          s_next.pcnt[k] = s_reg.pcnt[k] + 16'h0001;
          cap_ev[6+k] = 1'b0;
        end
      end
      if (!s_reg.ccfg[6+k][CCFG_GATE] ||
          (s_reg.ccfg[6+k][CCFG_GOC] && s_reg.count == s_reg.cmp[4+k])) begin
        s_next.blocked[k] = 1'b0;
      end
    end
    // AXI4-Lite write channel
    wr_go = s_reg.aw_have && s_reg.w_have && !s_reg.bvalid;
    if (s_axi_awvalid && !s_reg.aw_have) begin
      s_next.aw_have = 1'b1;
      s_next.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_reg.w_have) begin
      s_next.w_have = 1'b1;
      s_next.wdata = s_axi_wdata;
      s_next.wstrb = s_axi_wstrb;
    end
    if (s_reg.bvalid && s_axi_bready) begin
      s_next.bvalid = 1'b0;
    end
    m = merge(rd_word(s_reg, s_reg.awaddr), s_reg.wdata, s_reg.wstrb);
    wmask = merge(32'h0000_0000, s_reg.wdata, s_reg.wstrb);
    if (wr_go) begin
      s_next.aw_have = 1'b0;
      s_next.w_have = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = mapped(s_reg.awaddr) ? RESP_OKAY : RESP_SLVERR;
      case (s_reg.awaddr)
        OFF_CFG0: begin
          s_next.src = m[CFG0_SRC +: 2];
          s_next.ratio = m[CFG0_RATIO +: 5];
          s_next.irqsel = m[CFG0_IRQ +: 2];
        end
        OFF_CFG1: begin
          s_next.run = m[CFG1_RUN];
          s_next.ext_en = m[CFG1_EXT];
          s_next.match_en = m[CFG1_MATCH];
          s_next.ovf_en = m[CFG1_OVF];
          s_next.dirsel = m[CFG1_DIR +: 2];
        end
        OFF_COUNT: begin
          if (!hold) begin
            s_next.count = m[15:0];
          end
        end
        OFF_OCFG0: begin
          s_next.shape = m[OCFG0_SHAPE +: 3];
          s_next.base_reset_src_sel = m[OCFG0_BASE_RESET_SRC_SEL];
        end
        OFF_FSEL: s_next.fsel = m[7:0];
        OFF_FEN: s_next.fen = m[7:0];
        OFF_STAT: begin
          s_next.birq = s_reg.birq & ~wmask[STAT_BIRQ];
          s_next.cirq = s_reg.cirq & ~wmask[STAT_CIRQ +: 8];
        end
        OFF_TDIV6: s_next.tdiv[0] = m[15:0];
        OFF_TDIV7: s_next.tdiv[1] = m[15:0];
        default: begin
          if (s_reg.awaddr[7:5] == 3'h1) begin
            s_next.ccfg[s_reg.awaddr[4:2]] = m[7:0];
            s_next.ccfg[s_reg.awaddr[4:2]][CCFG_GSC] = 1'b0;
            if (m[CCFG_GSC] && s_reg.awaddr[4:3] == 2'h3) begin
              s_next.blocked[s_reg.awaddr[2]] = 1'b0;
            end
          end else if (s_reg.awaddr[7:5] == 3'h3) begin
            s_next.cmp[s_reg.awaddr[4:2]] = m[15:0];
          end
        end
      endcase
    end
    // AXI4-Lite read channel
    if (s_reg.rvalid && s_axi_rready) begin
      s_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !s_reg.rvalid) begin
      s_next.rvalid = 1'b1;
      s_next.rdata = rd_word(s_reg, s_axi_araddr);
      s_next.rresp = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    // Hardware events win over software clears
    if (birq_ev) begin
      s_next.birq = 1'b1;
    end
    for (int j = 0; j < NCH; j++) begin
      if (cap_ev[j]) begin
        s_next.cap[j] = s_reg.count;
        s_next.cirq[j] = 1'b1;
      end
    end
    for (int k = 0; k < 2; k++) begin
      if (cap_ev[6+k] && s_reg.ccfg[6+k][CCFG_GATE]) begin
        s_next.blocked[k] = 1'b1;
      end
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs
  assign s_axi_awready = !s_reg.aw_have;
  assign s_axi_wready = !s_reg.w_have;
  assign s_axi_bvalid = s_reg.bvalid;
  assign s_axi_bresp = s_reg.bresp;
  assign s_axi_arready = !s_reg.rvalid;
  assign s_axi_rvalid = s_reg.rvalid;
  assign s_axi_rdata = s_reg.rdata;
  assign s_axi_rresp = s_reg.rresp;
  assign peer_reset_out = s_reg.prst;
  assign base_irq_flag = s_reg.birq;
  assign capture_irq_flag = s_reg.cirq;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  stop_holds_zero_a: assert property (!s_reg.run |=> s_reg.count == CNT_RESET)
    else $error("stopped base timer not at zero");
  peer_reset_a: assert property (peer_reset_in |=> s_reg.count == CNT_RESET)
    else $error("peer reset did not clear the base timer");
  own_reset_out_a: assert property (!s_reg.run |=> peer_reset_out)
    else $error("own reset not passed to peer");
  capture_copy_a: assert property (cap_ev[1] |=> s_reg.cap[1] == $past(s_reg.count))
    else $error("capture value differs from base timer");
  capture_flag_a: assert property (cap_ev[3] |=> s_reg.cirq[3])
    else $error("capture flag not set");
  chan_disabled_a: assert property (!s_reg.fen[4] |-> !cap_ev[4])
    else $error("capture on a disabled channel");
  match_reset_a: assert property (tick && s_reg.pend && s_reg.dirsel == DIR_UP && !hold && !wr_go
    |=> s_reg.count == CNT_RESET)
    else $error("match reset missed");
  updn_turn_a: assert property (tick && s_reg.dirsel == DIR_UPDN && s_reg.count == CNT_TOP && !hold
    && !wr_go |=> s_reg.down ##0 s_reg.count == 16'hfffe)
    else $error("up/down did not turn at top");
  ovf15_flag_a: assert property (tick && s_reg.irqsel == 2'h2 && s_reg.dirsel == DIR_UP
    && s_reg.count == CNT_TOP && !hold |=> s_reg.birq)
    else $error("bit 15 overflow did not flag");
  gate_block_a: assert property (s_reg.ccfg[7][CCFG_GATE] && s_reg.blocked[1] |-> !cap_ev[7])
    else $error("trigger passed a closed gate");
  filter_three_a: assert property ($rose(s_reg.lvl[5]) && $past(s_reg.ccfg[5][CCFG_FILT +: 2]) == FLT_F1
    |-> $past(pin[5], 1) && $past(pin[5], 2) && $past(pin[5], 3))
    else $error("filter passed an unstable level");
  undiv_tick_a: assert property (s_reg.src == 2'h3 && s_reg.ratio == RATIO_NODIV
    && s_reg.dirsel == DIR_UP |-> tick)
    else $error("undivided source did not tick");

  presc_cap_c: cover property (cap_ev[6] && s_reg.ccfg[6][CCFG_PR]);
  match_reset_c: cover property (tick && s_reg.pend && !hold);
  updn_turn_c: cover property ($rose(s_reg.down));
  gate_reopen_c: cover property ($fell(s_reg.blocked[1]));
endmodule

`default_nettype wire

// file: verif/ctb_pin_model.sv
// Far-side model: capture trigger pins and quadrature encoder lines
`timescale 1ns/1ps
`default_nettype none
module ctb_pin_model (
  input wire logic clock,
  output logic [7:0] chan_pin,
  output logic quad_a,
  output logic quad_b
);
  // ==========================================================
  // Pin drivers
  initial begin
    chan_pin = 8'h00;
    quad_a = 1'b0;
    quad_b = 1'b0;
  end
  // Drive the masked trigger pins to a level and hold it for w cycles
  task automatic set_pins(input logic [7:0] m, input logic v, input int w);
    @(posedge clock);
    chan_pin <= v ? (chan_pin | m) : (chan_pin & ~m);
    repeat (w) @(posedge clock);
  endtask
  // Move the encoder one phase state and let it settle
  task automatic step(input logic [1:0] ab);
    @(posedge clock);
    quad_a <= ab[1];
    quad_b <= ab[0];
    repeat (6) @(posedge clock);
  endtask
endmodule
`default_nettype wire

// file: verif/capture_timer_base_group_test.sv
// Self-checking testbench of the capture timer base group
`timescale 1ns/1ps
`default_nettype none
module capture_timer_base_group_test;
  import ctb_pkg::*;
  // ==========================================================
  // Signals and scoreboard
  logic clock, rst_n, awv, awrdy, wv, wrdy, bv, brdy, arv, arrdy, rv, rrdy;
  logic qa, qb, ext_n, nev, peer_in, peer_out, birq;
  logic [7:0] awa, ara, pins, cirq;
  logic [31:0] wd, rdat, seed;
  logic [1:0] bresp, rresp;
  logic [15:0] v;
  logic [31:0] dq[$];
  logic [1:0] rq[$];
  logic [1:0] bq[$];
  logic [31:0] cfg[8] = '{32'h0, 32'h1, 32'h2, 32'h3, 32'h1, 32'h5, 32'h81, 32'h11};
  logic [15:0] tops[3] = '{16'h03ff, 16'h7fff, 16'hffff};
  logic [1:0] qseq[6] = '{2'h1, 2'h3, 2'h2, 2'h0, 2'h2, 2'h3};
  int n_fail, compares;
  ctb_group dut (
    .clock(clock), .rst_n(rst_n), .s_axi_awvalid(awv), .s_axi_awready(awrdy), .s_axi_awaddr(awa),
    .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_bvalid(bv),
    .s_axi_bready(brdy), .s_axi_bresp(bresp), .s_axi_arvalid(arv), .s_axi_arready(arrdy), .s_axi_araddr(ara),
    .s_axi_rvalid(rv), .s_axi_rready(rrdy), .s_axi_rdata(rdat), .s_axi_rresp(rresp), .chan_pin(pins),
    .quad_a(qa), .quad_b(qb), .ext_reset_input(ext_n), .neighbour_timer_event(nev),
    .peer_reset_in(peer_in), .peer_reset_out(peer_out), .base_irq_flag(birq), .capture_irq_flag(cirq)
  );
  ctb_pin_model pm (.clock(clock), .chan_pin(pins), .quad_a(qa), .quad_b(qb));
  // ==========================================================
  // Clock, watchdog and result monitor
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  initial begin
    repeat (20000) @(posedge clock);
    n_fail++;
    tally_and_finish();
  end
  always @(negedge clock) begin
    if (rv && rrdy) begin
      chk(dq.pop_front(), rdat);
      chk({30'h0, rq.pop_front()}, {30'h0, rresp});
    end
    if (bv && brdy) chk({30'h0, bq.pop_front()}, {30'h0, bresp});
  end
  // ==========================================================
  // Tasks
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value at %0t: expected %h got %h", $time, e, g);
    end
  endtask
  // Compare the flag and peer-reset pins mid-cycle, then resume on a rising edge
  task automatic chk_pins(input logic [31:0] e);
    @(negedge clock);
    chk({22'h0, peer_out, birq, cirq}, e);
    @(posedge clock);
  endtask
  task automatic tally_and_finish();
    if (n_fail == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Wait for a ready or valid sampled high mid-cycle, then resume on the following rising edge
  task automatic wait_hi(ref logic s);
    logic got;
    do begin
      @(negedge clock);
      got = s;
      @(posedge clock);
    end while (got !== 1'b1);
  endtask
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
    logic ta, tw, ha, hw;
    ta = 1'b0;
    tw = 1'b0;
    bq.push_back(r);
    awv <= 1'b1;
    awa <= a;
    wv <= 1'b1;
    wd <= d;
    brdy <= 1'b1;
    while (!(ta && tw)) begin
      @(negedge clock);
      ha = awrdy && !ta;
      hw = wrdy && !tw;
      @(posedge clock);
      if (ha) begin
        awv <= 1'b0;
        ta = 1'b1;
      end
      if (hw) begin
        wv <= 1'b0;
        tw = 1'b1;
      end
    end
    wait_hi(bv); // Bready stays up for the next write
  endtask
  task automatic bus_rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r = RESP_OKAY);
    dq.push_back(e);
    rq.push_back(r);
    arv <= 1'b1;
    ara <= a;
    rrdy <= 1'b1;
    wait_hi(arrdy);
    arv <= 1'b0;
    wait_hi(rv); // Rready stays up for the next read
  endtask
  // One single-cycle count event per two clocks
  task automatic ev(input int n);
    repeat (n) begin
      nev <= 1'b1;
      @(posedge clock);
      nev <= 1'b0;
      @(posedge clock);
    end
  endtask
  task automatic pulse_ev(input logic [7:0] m);
    pm.set_pins(m, 1'b1, 8);
    pm.set_pins(m, 1'b0, 8);
    ev(1);
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    {awv, wv, brdy, arv, rrdy, nev, peer_in, rst_n} = 8'h00;
    {awa, ara, wd} = 48'h0;
    ext_n = 1'b1;
    seed = 32'h0000_1624;
    n_fail = 0;
    compares = 0;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    bus_rd(OFF_CFG1, 32'h0000_0000);
    chk_pins(32'h0000_0200);
    bus_wr(OFF_COUNT, 32'h0000_1234);
    bus_rd(OFF_COUNT, 32'h0000_0000);
    bus_wr(8'hfc, 32'h0000_0001, RESP_SLVERR);
    bus_rd(8'hfc, 32'h0000_0000, RESP_SLVERR);
    for (int j = 0; j < NCH; j++) begin
      seed = lfsr(seed);
      bus_wr(OFF_CMP + 8'(4 * j), seed);
      bus_rd(OFF_CMP + 8'(4 * j), {16'h0000, seed[15:0]});
    end
    bus_wr(OFF_CFG0, {25'h0, RATIO_NODIV, SRC_NB});
    bus_wr(OFF_CFG1, 32'h0000_0001);
    seed = lfsr(seed);
    v = {4'h1, seed[11:0]};
    bus_wr(OFF_COUNT, {16'h0000, v});
    ev(5);
    bus_rd(OFF_COUNT, {16'h0000, v + 16'h0005});
    bus_wr(OFF_CFG0, {25'h0, 5'h01, SRC_NB});
    ev(8);
    bus_rd(OFF_COUNT, {16'h0000, v + 16'h0007});
    bus_wr(OFF_CFG0, {25'h0, RATIO_NODIV, SRC_NB});
    bus_wr(OFF_FSEL, 32'h0000_00fe);
    bus_wr(OFF_FEN, 32'h0000_00ef);
    for (int j = 1; j < NCH; j++) bus_wr(OFF_CCFG + 8'(4 * j), cfg[j]);
    bus_wr(OFF_TDIV6, 32'h0000_0002);
    bus_wr(OFF_STAT, 32'h0000_ffff);
    bus_wr(OFF_COUNT, 32'h0000_0200);
    // Rising edges at 0200h, falling edges at 0201h
    pm.set_pins(8'h1e, 1'b1, 8);
    ev(1);
    pm.set_pins(8'h1e, 1'b0, 8);
    bus_rd(OFF_CAPV + 8'h04, 32'h0000_0200);
    bus_rd(OFF_CAPV + 8'h08, 32'h0000_0201);
    bus_rd(OFF_CAPV + 8'h0c, 32'h0000_0201);
    bus_rd(OFF_CAPV + 8'h10, 32'h0000_0000);
    pm.set_pins(8'h20, 1'b1, 1);
    pm.set_pins(8'h20, 1'b0, 8);
    bus_rd(OFF_CAPV + 8'h14, 32'h0000_0000);
    pm.set_pins(8'h20, 1'b1, 8);
    bus_rd(OFF_CAPV + 8'h14, 32'h0000_0201);
    for (int k = 0; k < 3; k++) begin
      if (k == 2) bus_rd(OFF_CAPV + 8'h18, 32'h0000_0000);
      pulse_ev(8'h40);
    end
    bus_rd(OFF_CAPV + 8'h18, 32'h0000_0203);
    for (int k = 0; k < 3; k++) begin
      if (k == 2) bus_rd(OFF_CAPV + 8'h1c, 32'h0000_0204);
      if (k == 2) bus_wr(OFF_CCFG + 8'h1c, 32'h0000_0051);
      pulse_ev(8'h80);
    end
    bus_rd(OFF_CAPV + 8'h1c, 32'h0000_0206);
    bus_rd(OFF_STAT, 32'h0000_ee00);
    chk_pins(32'h0000_00ee);
    for (int k = 0; k < 3; k++) begin
      bus_wr(OFF_CFG0, {23'h0, 2'(k), RATIO_NODIV, SRC_NB});
      bus_wr(OFF_COUNT, {16'h0000, tops[0]});
      bus_wr(OFF_STAT, 32'h0000_ffff);
      ev(1);
      bus_rd(OFF_STAT, {31'h0, k == 0});
      bus_wr(OFF_COUNT, {16'h0000, tops[k]});
      bus_wr(OFF_STAT, 32'h0000_ffff);
      ev(1);
      bus_rd(OFF_STAT, 32'h0000_0001);
      chk_pins(32'h0000_0100);
    end
    bus_wr(OFF_CFG0, {25'h0, RATIO_NODIV, SRC_NB});
    bus_wr(OFF_CMP, 32'h0000_0003);
    bus_wr(OFF_OCFG0, 32'h0000_0000);
    bus_wr(OFF_COUNT, 32'h0000_0000);
    bus_wr(OFF_CFG1, 32'h0000_0005);
    ev(4);
    bus_rd(OFF_COUNT, 32'h0000_0004);
    ev(1);
    bus_rd(OFF_COUNT, 32'h0000_0000);
    ev(2);
    peer_in <= 1'b1;
    @(posedge clock);
    peer_in <= 1'b0;
    bus_rd(OFF_COUNT, 32'h0000_0000);
    bus_wr(OFF_CFG1, 32'h0000_0013);
    bus_wr(OFF_COUNT, 32'h0000_fffe);
    ev(3);
    bus_rd(OFF_COUNT, 32'h0000_fffd);
    ext_n <= 1'b0;
    repeat (4) @(posedge clock);
    ext_n <= 1'b1;
    repeat (4) @(posedge clock);
    bus_rd(OFF_COUNT, 32'h0000_0000);
    // Overflow of bit 9 resets the counter when selected
    bus_wr(OFF_OCFG0, 32'h0000_0008);
    bus_wr(OFF_CFG1, 32'h0000_0009);
    bus_wr(OFF_COUNT, 32'h0000_03ff);
    ev(1);
    bus_rd(OFF_COUNT, 32'h0000_0000);
    bus_wr(OFF_OCFG0, 32'h0000_0000);
    bus_wr(OFF_CFG0, {25'h0, RATIO_NODIV, SRC_QUAD});
    bus_wr(OFF_CFG1, 32'h0000_0021);
    bus_wr(OFF_COUNT, 32'h0000_0010);
    for (int k = 0; k < 6; k++) pm.step(qseq[k]);
    bus_rd(OFF_COUNT, 32'h0000_0012);
    // Undivided clock source ticks every cycle
    bus_wr(OFF_CFG1, 32'h0000_0001);
    bus_wr(OFF_CFG0, {25'h0, RATIO_NODIV, 2'h3});
    repeat (4) @(posedge clock);
    tally_and_finish();
  end
endmodule
`default_nettype wire
